// >>> phy_line_state_status.v
// Line state recognizer and read-only status registers of the ring physical layer controller
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
`include "phy_status_regs.vh"

module phy_line_state_status (
	ref_clk,
	reset,
	reg_addr,
	reg_wr_data,
	reg_wr,
	reg_rd,
	reg_rd_data,
	irq,
	pair_valid,
	pair_class,
	repeat_filter_state,
	pci_state,
	scrub_active_flag,
	pcm_state
);
	input  wire        ref_clk;
	input  wire        reset;
	input  wire [7:0]  reg_addr;
	input  wire [15:0] reg_wr_data;
	input  wire        reg_wr;
	input  wire        reg_rd;
	output reg  [15:0] reg_rd_data;
	output reg         irq;
	input  wire        pair_valid;
	input  wire [2:0]  pair_class;
	input  wire [1:0]  repeat_filter_state;
	input  wire [1:0]  pci_state;
	input  wire        scrub_active_flag;
	input  wire [3:0]  pcm_state;

	// Recognizer: hunting while a candidate state accumulates, locked once the full count is reached
	localparam [1:0] ST_HUNT   = 2'b01;
	localparam [1:0] ST_LOCKED = 2'b10;

	reg  [1:0]             recog_st_r;
	reg  [1:0]             recog_st_nxt;
	reg  [2:0]             current_line_state_r;
	reg  [2:0]             current_line_state_nxt;
	reg  [2:0]             cand_class_r;
	reg  [2:0]             cand_class_nxt;
	reg  [2:0]             like_pair_counter_r;
	reg  [2:0]             like_pair_counter_nxt;
	reg                    unknown_state_flag_r;
	reg                    unknown_state_flag_nxt;
	reg  [1:0]             repeat_filter_state_r;
	reg  [1:0]             pci_state_r;
	reg                    scrub_r;
	reg  [3:0]             pcm_state_r;
	reg  [`EV_WIDTH-1:0]   event_status_r;
	reg  [`EV_WIDTH-1:0]   event_status_nxt;
	reg  [`EV_WIDTH-1:0]   event_mask_r;
	reg  [`EV_WIDTH-1:0]   event_hit;
	reg  [15:0]            rd_data_nxt;
	wire [2:0]             in_class;
	wire [15:0]            line_status_word;
	wire [15:0]            conn_status_word;

	// Maps undefined and long idle pair classes onto noise so neither is taken directly as a line state
	function [2:0] clean_class;
		input [2:0] c;
		begin
			if (c == `LS_UNDEFINED || c == `LS_LONG_IDLE) begin
				clean_class = `LS_NOISE;
			end else begin
				clean_class = c;
			end
		end
	endfunction

	// Code to report when a candidate reaches its recognition count
	function [2:0] declared_code;
		input [2:0] c;
		input [2:0] cnt;
		begin
			if (c == `LS_SHORT_IDLE && cnt == `PAIR_COUNT_FULL) begin
				declared_code = `LS_LONG_IDLE;
			end else begin
				declared_code = c;
			end
		end
	endfunction

	assign in_class = clean_class(pair_class);

	always @* begin
		recog_st_nxt           = recog_st_r;
		current_line_state_nxt = current_line_state_r;
		cand_class_nxt         = cand_class_r;
		like_pair_counter_nxt  = like_pair_counter_r;
		unknown_state_flag_nxt = unknown_state_flag_r;
		if (pair_valid) begin
			if (in_class != cand_class_r) begin
				// A different pair starts a new candidate from scratch
				cand_class_nxt         = in_class;
				like_pair_counter_nxt  = 3'h0;
				unknown_state_flag_nxt = 1'b1;
				recog_st_nxt           = ST_HUNT;
			end else if (like_pair_counter_r != `PAIR_COUNT_FULL) begin
				like_pair_counter_nxt = like_pair_counter_r + 3'h1;
			end
			if (in_class == cand_class_r) begin
				case (recog_st_r)
					ST_HUNT: begin
						if (like_pair_counter_nxt == `PAIR_COUNT_FULL) begin
							// Eight like pairs: sixteen symbols
							current_line_state_nxt =
								declared_code(in_class, like_pair_counter_nxt);
							unknown_state_flag_nxt = 1'b0;
							recog_st_nxt           = ST_LOCKED;
						end else if (in_class == `LS_SHORT_IDLE &&
							like_pair_counter_nxt == `PAIR_COUNT_SHORT_IDLE) begin
							// Idle is known after four symbols; stays hunting toward long idle
							current_line_state_nxt = `LS_SHORT_IDLE;
							unknown_state_flag_nxt = 1'b0;
						end
					end
					ST_LOCKED: begin
						recog_st_nxt = ST_LOCKED;
					end
					default: begin
						recog_st_nxt = ST_HUNT;
					end
				endcase
			end
		end
	end

	assign line_status_word = {8'h00,
		current_line_state_r,
		recog_st_r[1],
		unknown_state_flag_r,
		like_pair_counter_r};

	assign conn_status_word = {repeat_filter_state_r,
		pci_state_r,
		scrub_r,
		pcm_state_r,
		7'h00};

	always @* begin
		event_hit = {`EV_WIDTH{1'b0}};
		event_hit[`EV_LINE_STATE_BIT] = (current_line_state_nxt != current_line_state_r);
		event_hit[`EV_UNKNOWN_BIT]    = unknown_state_flag_nxt & ~unknown_state_flag_r;
		event_hit[`EV_RF_BIT]         = (repeat_filter_state != repeat_filter_state_r);
		event_hit[`EV_PCI_BIT]        = (pci_state != pci_state_r);
		event_hit[`EV_PCM_BIT]        = (pcm_state != pcm_state_r);
	end

	// Event bits clear on read; a new event in the same cycle wins over the clear
	always @* begin
		event_status_nxt = event_status_r;
		if (reg_rd && reg_addr == `EVENT_STATUS_OFFSET) begin
			event_status_nxt = {`EV_WIDTH{1'b0}};
		end
		event_status_nxt = event_status_nxt | event_hit;
	end

	// Line and connection status reads only select a word; an event status read also clears the event bits
	always @* begin
		rd_data_nxt = `READ_ZERO;
		if (reg_rd) begin
			if (reg_addr == `LINE_STATUS_OFFSET) begin
				rd_data_nxt = line_status_word;
			end else if (reg_addr == `CONN_STATUS_OFFSET) begin
				rd_data_nxt = conn_status_word;
			end else if (reg_addr == `EVENT_STATUS_OFFSET) begin
				rd_data_nxt = {{(16-`EV_WIDTH){1'b0}}, event_status_r};
			end else if (reg_addr == `EVENT_MASK_OFFSET) begin
				rd_data_nxt = {{(16-`EV_WIDTH){1'b0}}, event_mask_r};
			end else begin
				rd_data_nxt = `READ_ZERO;
			end
		end
	end

	always @(posedge ref_clk) begin
		if (reset) begin
			recog_st_r           <= ST_HUNT;
			current_line_state_r <= `LINE_STATE_RESET;
			cand_class_r         <= `LS_NOISE;
			like_pair_counter_r  <= 3'h0;
			unknown_state_flag_r <= 1'b1;
			repeat_filter_state_r           <= `RF_REPEAT;
			pci_state_r          <= `PCI_REMOVED;
			scrub_r              <= 1'b0;
			pcm_state_r          <= `PCM_OFF;
			event_status_r       <= {`EV_WIDTH{1'b0}};
			event_mask_r         <= `EVENT_MASK_RESET;
			reg_rd_data          <= `READ_ZERO;
			irq                  <= 1'b0;
		end else begin
			recog_st_r           <= recog_st_nxt;
			current_line_state_r <= current_line_state_nxt;
			cand_class_r         <= cand_class_nxt;
			like_pair_counter_r  <= like_pair_counter_nxt;
			unknown_state_flag_r <= unknown_state_flag_nxt;
			repeat_filter_state_r           <= repeat_filter_state;
			pci_state_r          <= pci_state;
			scrub_r              <= scrub_active_flag;
			pcm_state_r          <= pcm_state;
			event_status_r       <= event_status_nxt;
			// Only the mask is writable; status words ignore writes
			if (reg_wr && reg_addr == `EVENT_MASK_OFFSET) begin
				event_mask_r <= reg_wr_data[`EV_WIDTH-1:0];
			end
			reg_rd_data <= rd_data_nxt;
			irq         <= |(event_status_nxt & event_mask_r);
		end
	end

endmodule

// >>> phy_status_regs.vh
// Offsets, field positions, codes and counts of the line and connection status registers
`ifndef PHY_STATUS_REGS_VH
`define PHY_STATUS_REGS_VH

// Register offsets (word addresses on the register port)
`define LINE_STATUS_OFFSET       8'h10
`define CONN_STATUS_OFFSET       8'h11
`define EVENT_STATUS_OFFSET      8'h16
`define EVENT_MASK_OFFSET        8'h17

// Line status register fields
`define LS_STATE_MSB             7
`define LS_STATE_LSB             5
`define LS_RECOG_BIT             4
`define LS_UNKNOWN_BIT           3
`define LS_COUNT_MSB             2
`define LS_COUNT_LSB             0

// Connection status register fields
`define CS_RF_MSB                15
`define CS_RF_LSB                14
`define CS_PCI_MSB               13
`define CS_PCI_LSB               12
`define CS_SCRUB_BIT             11
`define CS_PCM_MSB               10
`define CS_PCM_LSB               7

// Event status / mask bits
`define EV_LINE_STATE_BIT        0
`define EV_UNKNOWN_BIT           1
`define EV_RF_BIT                2
`define EV_PCI_BIT               3
`define EV_PCM_BIT               4
`define EV_WIDTH                 5

// Line state codes; received pair classes use the same codes
`define LS_NOISE                 3'h0
`define LS_ACTIVE                3'h1
`define LS_UNDEFINED             3'h2
`define LS_SHORT_IDLE            3'h3
`define LS_QUIET                 3'h4
`define LS_MASTER                3'h5
`define LS_HALT                  3'h6
`define LS_LONG_IDLE             3'h7

// Repeat filter, insertion and connection management codes
`define RF_REPEAT                2'h0
`define RF_IDLE                  2'h1
`define RF_FIRST_HALT            2'h2
`define RF_SECOND_HALT           2'h3
`define PCI_REMOVED              2'h0
`define PCI_INSERTING_SCRUB      2'h1
`define PCI_REMOVING_SCRUB       2'h2
`define PCI_INSERTED             2'h3
`define PCM_OFF                  4'h0
`define PCM_MAINTENANCE          4'h9

// Like-pair counts: full recognition at seven, short idle after two pairs
`define PAIR_COUNT_FULL          3'h7
`define PAIR_COUNT_SHORT_IDLE    3'h1

// Reset values
`define LINE_STATE_RESET         3'h0
`define EVENT_MASK_RESET         5'h00
`define READ_ZERO                16'h0000

`endif

// >>> phy_status_asserts.sv
// Checker for the status register read port
`timescale 1ns/100ps
module phy_status_asserts (
	input wire        ref_clk,
	input wire        reset,
	input wire [7:0]  reg_addr,
	input wire        reg_rd,
	input wire [15:0] reg_rd_data,
	input wire        irq,
	input wire [1:0]  repeat_filter_state,
	input wire [1:0]  pci_state,
	input wire        scrub_active_flag,
	input wire [3:0]  pcm_state
);
	logic       cr;
	logic       lr;
	wire [15:0] d = reg_rd_data;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	always @(posedge ref_clk) begin
		cr <= reg_rd && reg_addr == 8'h11;
		lr <= reg_rd && reg_addr == 8'h10;
	end
	// Inputs pass one field register, then the read data register
	property p_rf; cr |-> d[15:14] == $past(repeat_filter_state, 2); endproperty
	a_rf: assert property (p_rf) else $error("repeat filter field wrong");
	property p_pci; cr |-> d[13:12] == $past(pci_state, 2); endproperty
	a_pci: assert property (p_pci) else $error("insertion field wrong");
	property p_scrub; cr |-> d[11] == $past(scrub_active_flag, 2); endproperty
	a_scrub: assert property (p_scrub) else $error("scrub flag wrong");
	property p_pcm; cr |-> d[10:7] == $past(pcm_state, 2); endproperty
	a_pcm: assert property (p_pcm) else $error("management field wrong");
	property p_lock; lr && d[4] |-> d[2:0] == 3'h7 && !d[3]; endproperty
	a_lock: assert property (p_lock) else $error("locked without full count");
	property p_cnt; lr && d[2:0] == 3'h7 |-> !d[3]; endproperty
	a_cnt: assert property (p_cnt) else $error("unknown set at full count");
	property p_full; lr && !d[3] && d[7:5] != 3'h3 |-> d[2:0] == 3'h7; endproperty
	a_full: assert property (p_full) else $error("state known too early");
	property p_short; lr && !d[3] && d[2:0] != 3'h7 |-> d[7:5] == 3'h3; endproperty
	a_short: assert property (p_short) else $error("early state not short idle");
	c_lock: cover property (lr && d[4]);
	c_short: cover property (lr && d[7:5] == 3'h3 && !d[4]);
	c_irq: cover property (irq);
endmodule

// >>> node_host.sv
// Node processor model driving the register port
`timescale 1ns/100ps
module node_host (
	input  wire         ref_clk,
	output logic [7:0]  reg_addr,
	output logic [15:0] reg_wr_data,
	output logic        reg_wr,
	output logic        reg_rd,
	input  wire  [15:0] reg_rd_data
);
	initial begin
		reg_addr = 8'h00;
		reg_wr_data = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released address is inverted so a stale value never looks valid
	task wr(input [7:0] a, input [15:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wr_data <= ~v;
	endtask
	task rd(input [7:0] a, output [15:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		v = reg_rd_data;
	endtask
endmodule

// >>> phy_line_state_status_bench.sv
// Bench for the line and connection status registers
`timescale 1ns/100ps
module phy_line_state_status_bench;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        pair_valid = 1'b0;
	logic [2:0]  pair_class = 3'h0;
	logic [1:0]  repeat_filter_state = 2'h0;
	logic [1:0]  pci_state = 2'h0;
	logic        scrub_active_flag = 1'b0;
	logic [3:0]  pcm_state = 4'h0;
	wire  [7:0]  reg_addr;
	wire  [15:0] reg_wr_data;
	wire  [15:0] reg_rd_data;
	wire         reg_wr;
	wire         reg_rd;
	wire         irq;
	logic [15:0] d;
	logic [2:0]  prev;
	logic [2:0]  cls [5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h0};
	int          error_cnt = 0;
	int          n_tests = 0;
	always #5 ref_clk = ~ref_clk;
	phy_line_state_status u_phy_line_state_status (.ref_clk(ref_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rd_data(reg_rd_data), .irq(irq), .pair_valid(pair_valid), .pair_class(pair_class),
		.repeat_filter_state(repeat_filter_state), .pci_state(pci_state), .scrub_active_flag(scrub_active_flag),
		.pcm_state(pcm_state));
	node_host u_node_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data));
	task chk(input string nm, input [15:0] e, input [15:0] s);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task rdchk(input [7:0] a, input [15:0] e);
		u_node_host.rd(a, d);
		chk("reg_rd_data", e, d);
	endtask
	task irqchk(input logic e);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("irq", {15'h0000, e}, {15'h0000, irq});
	endtask
	task send(input [2:0] c, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			pair_valid <= 1'b1;
			pair_class <= c;
		end
		@(posedge ref_clk);
		pair_valid <= 1'b0;
	endtask
	task conclude;
		$display("mismatches %0d of %0d checks", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		rdchk(8'h10, 16'h0008);
		send(3'h0, 7);
		rdchk(8'h10, 16'h0017);
		prev = 3'h0;
		foreach (cls[i]) begin
			send(cls[i], 1);
			rdchk(8'h10, {8'h00, prev, 5'h08});
			send(cls[i], 7);
			rdchk(8'h10, {8'h00, cls[i], 5'h17});
			prev = cls[i];
		end
		send(3'h3, 2);
		rdchk(8'h10, 16'h0061);
		send(3'h3, 6);
		rdchk(8'h10, 16'h00F7);
		@(posedge ref_clk);
		#1;
		chk("reg_rd_data idle", 16'h0000, reg_rd_data);
		send(3'h7, 1);
		rdchk(8'h10, 16'h00E8);
		send(3'h2, 7);
		rdchk(8'h10, 16'h0017);
		u_node_host.wr(8'h17, 16'h0001);
		u_node_host.rd(8'h16, d);
		send(3'h1, 8);
		irqchk(1'b1);
		rdchk(8'h16, 16'h0003);
		irqchk(1'b0);
		u_node_host.wr(8'h17, 16'h0000);
		send(3'h4, 8);
		irqchk(1'b0);
		rdchk(8'h16, 16'h0003);
		u_node_host.wr(8'h10, 16'hFFFF);
		rdchk(8'h10, 16'h0097);
		rdchk(8'h10, 16'h0097);
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			repeat_filter_state <= i[1:0];
			pci_state <= ~i[1:0];
			scrub_active_flag <= i[0];
			pcm_state <= i[3:0];
			u_node_host.wr(8'h11, 16'hFFFF);
			rdchk(8'h11, {i[1:0], ~i[1:0], i[0], i[3:0], 7'h00});
		end
		rdchk(8'h20, 16'h0000);
		conclude;
	end
endmodule
bind phy_line_state_status phy_status_asserts u_phy_status_asserts (.ref_clk(ref_clk),
	.reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .irq(irq),
	.repeat_filter_state(repeat_filter_state), .pci_state(pci_state), .scrub_active_flag(scrub_active_flag),
	.pcm_state(pcm_state));
